// >>> rtl/apm_pkg.sv
/*
 * Activity power monitor constants: offsets, port ranges, timing.
 * Assumes a 200 MHz clock and 16-bit I/O port addresses.
 */
package apm_pkg;

    // ********************
    // Clock and timing
    // ********************
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned DRIVE_QUIET_S = 4;
    localparam longint unsigned DRIVE_QUIET_CYC =
        longint'(DRIVE_QUIET_S) * longint'(CLK_HZ);
    localparam int unsigned REFRESH_SLOW_HZ = 32_000;
    localparam int unsigned REFRESH_DIV = CLK_HZ / REFRESH_SLOW_HZ;
    localparam int unsigned REFRESH_DIV_W = 13;
    localparam logic [REFRESH_DIV_W-1:0] REFRESH_DIV_LAST =
        REFRESH_DIV_W'(REFRESH_DIV - 1);
    localparam int unsigned TICK_DIV = 200;
    localparam logic [7:0] TICK_DIV_LAST = 8'(TICK_DIV - 1);

    // ********************
    // Subsystems
    // ********************
    localparam int unsigned NSUB = 6;
    localparam int unsigned SUB_KBD = 0;
    localparam int unsigned SUB_MOUSE = 1;
    localparam int unsigned SUB_HDD = 2;
    localparam int unsigned SUB_SERIAL = 3;
    localparam int unsigned SUB_PRN = 4;
    localparam int unsigned SUB_FDD = 5;
    localparam int unsigned TMR_W = 32;
    localparam int unsigned SAVE_AW = 4;
    localparam int unsigned SAVE_DW = 32;

    // ********************
    // Monitored port addresses
    // ********************
    localparam logic [15:0] P_KBD_DATA = 16'h0060;
    localparam logic [15:0] P_KBD_CMD = 16'h0064;
    localparam logic [15:0] P_HDD1_LO = 16'h01f0;
    localparam logic [15:0] P_HDD1_HI = 16'h01f7;
    localparam logic [15:0] P_HDD2_LO = 16'h0170;
    localparam logic [15:0] P_HDD2_HI = 16'h0177;
    localparam logic [15:0] P_HDD2_CTL = 16'h0376;
    localparam logic [15:0] P_COM1_LO = 16'h03f8;
    localparam logic [15:0] P_COM1_HI = 16'h03ff;
    localparam logic [15:0] P_COM2_LO = 16'h02f8;
    localparam logic [15:0] P_COM2_HI = 16'h02ff;
    localparam logic [15:0] P_PRN1_LO = 16'h0378;
    localparam logic [15:0] P_PRN1_HI = 16'h037a;
    localparam logic [15:0] P_PRN2_LO = 16'h0278;
    localparam logic [15:0] P_PRN2_HI = 16'h027a;
    localparam logic [15:0] P_PRN3_LO = 16'h03bc;
    localparam logic [15:0] P_PRN3_HI = 16'h03be;
    localparam logic [15:0] P_FDD_LO = 16'h03f0;
    localparam logic [15:0] P_FDD_HI = 16'h03f7;

    // ********************
    // Register map
    // ********************
    localparam logic [7:0] R_CTRL = 8'h00;
    localparam logic [7:0] R_STATUS = 8'h04;
    localparam logic [7:0] R_EVENT = 8'h08;
    localparam logic [7:0] R_STBY_TO = 8'h0c;
    localparam logic [7:0] R_SUSP_TO = 8'h10;
    localparam logic [7:0] R_SAVE_ADDR = 8'h14;
    localparam logic [7:0] R_SAVE_DATA = 8'h18;
    localparam logic [7:0] R_TMR_BASE = 8'h20;

    // Control register bits.
    localparam int unsigned C_ON_BATT = 0;
    localparam int unsigned C_LOWBAT2 = 1;
    localparam int unsigned C_SUSP_REQ = 2;
    localparam int unsigned C_SAVE_DONE = 3;
    localparam int unsigned C_SMI_DONE = 4;
    localparam int unsigned C_ECO_MON = 5;
    localparam int unsigned C_SCR_TO = 6;
    localparam int unsigned C_WAKE = 7;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] STBY_TO_RST = 32'h0000_ffff;
    localparam logic [31:0] SUSP_TO_RST = 32'h0002_0000;

    typedef enum logic [2:0] {
        APM_ON,
        APM_STANDBY,
        APM_SUSP_WAIT,
        APM_SUSP_SAVE,
        APM_SUSPEND
    } apm_state_t;

endpackage

// >>> rtl/apm_save_ram.sv
/*
 * Small management save memory with registered read data.
 * Assumes one clock; write and read may occur in the same cycle.
 */
module apm_save_ram (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic wr_en,
    input wire logic [apm_pkg::SAVE_AW-1:0] wr_addr,
    input wire logic [apm_pkg::SAVE_DW-1:0] wr_data,
    // Read port
    input wire logic [apm_pkg::SAVE_AW-1:0] rd_addr,
    output logic [apm_pkg::SAVE_DW-1:0] rd_data
);

    logic [apm_pkg::SAVE_DW-1:0] mem [0:(1<<apm_pkg::SAVE_AW)-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

// >>> rtl/apm_monitor.sv
/*
 * Activity monitor and power state control.
 * Assumes io_cycle is on clk; pins are asynchronous.
 */
// Functional notes
// - Standby activity raises management interrupt, wakes
// - Watch keyboard, mouse, both drive port ranges
// - Serial port ranges count as activity
// - Printer port ranges count as activity
// - Stop-clock in idle, drop on interrupts
// - Standby entry reloads timers, slows processor
// - Any drive access leaves local standby
// - Timer suspend only when all timers expired; key, request or low battery suspend at once
// - Short suspend timeout skips standby entirely
// - Suspend key raises management interrupt
// - Drives quiet four seconds before suspend continues
// - Save drive and coprocessor state first
// - Save memory open only during service
// - Suspend keeps memory, refresh at 32KHz
// - Suspend disables clock generator outputs
// - Video refresh 32KHz, panel off, converter low
// - Screen timeout: eco suspends graphics, else standby
// - On battery allow low-battery, timeout, key suspend
module apm_monitor #(
    parameter longint unsigned QUIET_CYC = apm_pkg::DRIVE_QUIET_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Host I/O cycle observation
    input wire logic io_cycle,
    input wire logic [15:0] io_addr,
    // Asynchronous pins
    input wire logic irq_kbd,
    input wire logic irq_mouse,
    input wire logic susp_key,
    // Power controls
    output logic smi,
    output logic stop_clk,
    output logic cpu_slow,
    output logic clkgen_off,
    output logic mem_refresh_slow,
    output logic refresh_tick,
    output logic panel_off,
    output logic dac_low,
    output logic gfx_suspend,
    output logic gfx_standby,
    output logic save_mem_open,
    output logic [2:0] pm_state
);

    // ********************
    // Pin synchronisers
    // ********************
    logic [2:0] pin_meta_ff;
    logic [2:0] pin_sync_ff;
    logic susp_key_d_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta_ff <= 3'h0;
            pin_sync_ff <= 3'h0;
            susp_key_d_ff <= 1'b0;
        end else begin
            pin_meta_ff <= {susp_key, irq_mouse, irq_kbd};
            pin_sync_ff <= pin_meta_ff;
            susp_key_d_ff <= pin_sync_ff[2];
        end
    end
    wire key_press = pin_sync_ff[2] && !susp_key_d_ff;

    // ********************
    // Address decode
    // ********************
    wire a_kbd = io_cycle && (io_addr == apm_pkg::P_KBD_DATA ||
        io_addr == apm_pkg::P_KBD_CMD);
    wire a_hdd1 = io_addr >= apm_pkg::P_HDD1_LO &&
        io_addr <= apm_pkg::P_HDD1_HI;
    wire a_hdd2 = (io_addr >= apm_pkg::P_HDD2_LO &&
        io_addr <= apm_pkg::P_HDD2_HI) || io_addr == apm_pkg::P_HDD2_CTL;
    wire a_hdd = io_cycle && (a_hdd1 || a_hdd2);
    wire a_ser = io_cycle && ((io_addr >= apm_pkg::P_COM1_LO &&
        io_addr <= apm_pkg::P_COM1_HI) || (io_addr >= apm_pkg::P_COM2_LO &&
        io_addr <= apm_pkg::P_COM2_HI));
    wire a_prn = io_cycle && ((io_addr >= apm_pkg::P_PRN1_LO &&
        io_addr <= apm_pkg::P_PRN1_HI) || (io_addr >= apm_pkg::P_PRN2_LO &&
        io_addr <= apm_pkg::P_PRN2_HI) || (io_addr >= apm_pkg::P_PRN3_LO &&
        io_addr <= apm_pkg::P_PRN3_HI));
    wire a_fdd = io_cycle && io_addr >= apm_pkg::P_FDD_LO &&
        io_addr <= apm_pkg::P_FDD_HI && !a_ser;

    logic [apm_pkg::NSUB-1:0] act;
    assign act[apm_pkg::SUB_KBD] = a_kbd || pin_sync_ff[0];
    assign act[apm_pkg::SUB_MOUSE] = pin_sync_ff[1];
    assign act[apm_pkg::SUB_HDD] = a_hdd;
    assign act[apm_pkg::SUB_SERIAL] = a_ser;
    assign act[apm_pkg::SUB_PRN] = a_prn;
    assign act[apm_pkg::SUB_FDD] = a_fdd;
    wire any_act = |act;

    // ********************
    // Registers
    // ********************
    logic [31:0] ctrl_ff;
    logic [31:0] stby_to_ff;
    logic [31:0] susp_to_ff;
    logic [apm_pkg::SAVE_AW-1:0] save_addr_ff;
    logic [apm_pkg::NSUB-1:0] event_ff;
    apm_pkg::apm_state_t state_ff;
    apm_pkg::apm_state_t nxt_state;

    wire wr_ctrl = reg_wr && reg_addr == apm_pkg::R_CTRL;
    wire wr_event = reg_wr && reg_addr == apm_pkg::R_EVENT;
    wire wr_save = reg_wr && reg_addr == apm_pkg::R_SAVE_DATA;
    wire on_batt = ctrl_ff[apm_pkg::C_ON_BATT];
    wire lowbat2 = ctrl_ff[apm_pkg::C_LOWBAT2];
    wire in_susp_seq = state_ff == apm_pkg::APM_SUSP_WAIT ||
        state_ff == apm_pkg::APM_SUSP_SAVE;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_ff <= apm_pkg::CTRL_RST;
            stby_to_ff <= apm_pkg::STBY_TO_RST;
            susp_to_ff <= apm_pkg::SUSP_TO_RST;
            save_addr_ff <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= reg_wdata;
            end else begin
                ctrl_ff[apm_pkg::C_SUSP_REQ] <= 1'b0;
                ctrl_ff[apm_pkg::C_SAVE_DONE] <= 1'b0;
                ctrl_ff[apm_pkg::C_SMI_DONE] <= 1'b0;
                ctrl_ff[apm_pkg::C_WAKE] <= 1'b0;
            end
            if (reg_wr && reg_addr == apm_pkg::R_STBY_TO) begin
                stby_to_ff <= reg_wdata;
            end
            if (reg_wr && reg_addr == apm_pkg::R_SUSP_TO) begin
                susp_to_ff <= reg_wdata;
            end
            if (reg_wr && reg_addr == apm_pkg::R_SAVE_ADDR) begin
                save_addr_ff <= reg_wdata[apm_pkg::SAVE_AW-1:0];
            end
        end
    end

    // Events are sticky; a new event beats a write-one-to-clear.
    logic [apm_pkg::NSUB-1:0] nxt_event;
    assign nxt_event = (event_ff & ~(wr_event ?
        reg_wdata[apm_pkg::NSUB-1:0] : '0)) | act;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            event_ff <= '0;
        end else begin
            event_ff <= nxt_event;
        end
    end

    // ********************
    // Inactivity timers
    // ********************
    logic [apm_pkg::TMR_W-1:0] tmr_ff [apm_pkg::NSUB];
    logic [apm_pkg::NSUB-1:0] expired;
    logic [7:0] tick_cnt_ff;
    wire tick = tick_cnt_ff == apm_pkg::TICK_DIV_LAST;
    wire standby_entry = nxt_state == apm_pkg::APM_STANDBY &&
        state_ff != apm_pkg::APM_STANDBY;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_ff <= 8'h00;
        end else begin
            tick_cnt_ff <= tick ? 8'h00 : tick_cnt_ff + 8'h01;
        end
    end

    // Timers count in microsecond ticks so 32-bit reload spans over an hour.
    for (genvar i = 0; i < apm_pkg::NSUB; i++) begin : g_tmr
        assign expired[i] = tmr_ff[i] == '0;
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                tmr_ff[i] <= apm_pkg::STBY_TO_RST;
            end else if (act[i]) begin
                tmr_ff[i] <= susp_to_ff;
            end else if (standby_entry) begin
                tmr_ff[i] <= susp_to_ff;
            end else if (tick && !expired[i]) begin
                tmr_ff[i] <= tmr_ff[i] - 32'h1;
            end
        end
    end
    wire all_expired = &expired;

    // Standby timer runs on the same activity; the shorter one wins.
    logic [31:0] idle_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idle_ff <= 32'h0;
        end else if (any_act || state_ff != apm_pkg::APM_ON) begin
            idle_ff <= 32'h0;
        end else if (tick) begin
            idle_ff <= idle_ff + 32'h1;
        end
    end
    wire stby_due = idle_ff >= stby_to_ff;
    wire susp_first = susp_to_ff < stby_to_ff;

    // ********************
    // Drive quiet window
    // ********************
    logic [33:0] quiet_ff;
    wire drive_act = act[apm_pkg::SUB_HDD] || act[apm_pkg::SUB_FDD];
    wire quiet_done = quiet_ff >= 34'(QUIET_CYC);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            quiet_ff <= 34'h0;
        end else if (drive_act || state_ff != apm_pkg::APM_SUSP_WAIT) begin
            quiet_ff <= 34'h0;
        end else if (!quiet_done) begin
            quiet_ff <= quiet_ff + 34'h1;
        end
    end

    // ********************
    // Power state machine
    // ********************
    wire susp_req = key_press || ctrl_ff[apm_pkg::C_SUSP_REQ] ||
        (on_batt && lowbat2);
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            apm_pkg::APM_ON: begin
                if (susp_req || (all_expired && susp_first)) begin
                    nxt_state = apm_pkg::APM_SUSP_WAIT;
                end else if (stby_due && !any_act) begin
                    nxt_state = apm_pkg::APM_STANDBY;
                end
            end
            apm_pkg::APM_STANDBY: begin
                if (any_act || act[apm_pkg::SUB_HDD]) begin
                    nxt_state = apm_pkg::APM_ON;
                end else if (susp_req || all_expired) begin
                    nxt_state = apm_pkg::APM_SUSP_WAIT;
                end
            end
            apm_pkg::APM_SUSP_WAIT: begin
                if (quiet_done) begin
                    nxt_state = apm_pkg::APM_SUSP_SAVE;
                end
            end
            apm_pkg::APM_SUSP_SAVE: begin
                if (ctrl_ff[apm_pkg::C_SAVE_DONE]) begin
                    nxt_state = apm_pkg::APM_SUSPEND;
                end
            end
            apm_pkg::APM_SUSPEND: begin
                if (ctrl_ff[apm_pkg::C_WAKE]) begin
                    nxt_state = apm_pkg::APM_ON;
                end
            end
            default: nxt_state = apm_pkg::APM_ON;
        endcase
    end

    // ********************
    // Management interrupt and save memory window
    // ********************
    wire smi_cause = (state_ff == apm_pkg::APM_STANDBY && any_act) ||
        key_press || (nxt_state == apm_pkg::APM_SUSP_WAIT &&
        !in_susp_seq);
    logic smi_ff;
    wire nxt_smi = smi_cause || (smi_ff && !ctrl_ff[apm_pkg::C_SMI_DONE]);
    logic [apm_pkg::REFRESH_DIV_W-1:0] ref_cnt_ff;
    wire ref_wrap = ref_cnt_ff == apm_pkg::REFRESH_DIV_LAST;
    wire susp_now = nxt_state == apm_pkg::APM_SUSPEND;
    wire scr_to = ctrl_ff[apm_pkg::C_SCR_TO];
    wire eco = ctrl_ff[apm_pkg::C_ECO_MON];
    logic gfx_susp_ff;
    logic gfx_stby_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            smi_ff <= 1'b0;
            state_ff <= apm_pkg::APM_ON;
            ref_cnt_ff <= '0;
            gfx_susp_ff <= 1'b0;
            gfx_stby_ff <= 1'b0;
        end else begin
            smi_ff <= nxt_smi;
            state_ff <= nxt_state;
            ref_cnt_ff <= ref_wrap ? '0 : ref_cnt_ff + 1'b1;
            if (scr_to) begin
                gfx_susp_ff <= eco;
                gfx_stby_ff <= !eco;
            end else if (any_act) begin
                gfx_susp_ff <= 1'b0;
                gfx_stby_ff <= 1'b0;
            end
        end
    end

    logic [apm_pkg::SAVE_DW-1:0] save_rd;
    // Save memory only writes while the interrupt is in service.
    apm_save_ram u_save (
        .clk(clk),
        .wr_en(wr_save && smi_ff),
        .wr_addr(save_addr_ff),
        .wr_data(reg_wdata),
        .rd_addr(save_addr_ff),
        .rd_data(save_rd)
    );

    // ********************
    // Registered outputs
    // ********************
    wire in_stby_next = nxt_state == apm_pkg::APM_STANDBY;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            smi <= 1'b0;
            stop_clk <= 1'b0;
            cpu_slow <= 1'b0;
            clkgen_off <= 1'b0;
            mem_refresh_slow <= 1'b0;
            refresh_tick <= 1'b0;
            panel_off <= 1'b0;
            dac_low <= 1'b0;
            gfx_suspend <= 1'b0;
            gfx_standby <= 1'b0;
            save_mem_open <= 1'b0;
            pm_state <= 3'h0;
        end else begin
            smi <= nxt_smi;
            save_mem_open <= nxt_smi;
            stop_clk <= (in_stby_next && !any_act && !nxt_smi) ||
                susp_now;
            cpu_slow <= in_stby_next;
            clkgen_off <= susp_now;
            mem_refresh_slow <= susp_now;
            refresh_tick <= susp_now && ref_wrap;
            panel_off <= susp_now || gfx_susp_ff || gfx_stby_ff;
            dac_low <= susp_now || gfx_susp_ff;
            gfx_suspend <= susp_now || gfx_susp_ff;
            gfx_standby <= gfx_stby_ff;
            pm_state <= nxt_state;
        end
    end

    // ********************
    // Register read
    // ********************
    wire in_tmr = reg_addr >= apm_pkg::R_TMR_BASE &&
        reg_addr < apm_pkg::R_TMR_BASE + 8'(4 * apm_pkg::NSUB);
    wire [7:0] tmr_off = reg_addr - apm_pkg::R_TMR_BASE;
    wire [2:0] tmr_idx = tmr_off[4:2];
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        case (reg_addr)
            apm_pkg::R_CTRL: rd_mux = ctrl_ff;
            apm_pkg::R_STATUS: rd_mux = {24'h0, all_expired, smi_ff,
                save_mem_open, quiet_done, stop_clk, 3'(state_ff)};
            apm_pkg::R_EVENT: rd_mux = 32'(event_ff);
            apm_pkg::R_STBY_TO: rd_mux = stby_to_ff;
            apm_pkg::R_SUSP_TO: rd_mux = susp_to_ff;
            apm_pkg::R_SAVE_ADDR: rd_mux = 32'(save_addr_ff);
            apm_pkg::R_SAVE_DATA: rd_mux = smi_ff ? save_rd : 32'h0;
            default: rd_mux = in_tmr ? tmr_ff[tmr_idx] : 32'h0;
        endcase
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end

endmodule

// >>> test/apm_monitor_chk.sv
/* Port assertions for the activity power monitor.
   Assumes a bind to apm_monitor and one clock domain. */
module apm_monitor_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Observed ports
    input wire logic io_cycle,
    input wire logic [15:0] io_addr,
    input wire logic smi,
    input wire logic stop_clk,
    input wire logic cpu_slow,
    input wire logic clkgen_off,
    input wire logic mem_refresh_slow,
    input wire logic refresh_tick,
    input wire logic panel_off,
    input wire logic dac_low,
    input wire logic save_mem_open,
    input wire logic [2:0] pm_state
);
    wire logic stby = pm_state == 3'h1;
    wire logic susp = pm_state == 3'h4;
    wire logic drv = io_addr[15:3] inside {13'h03e, 13'h02e}
        || io_addr == 16'h0376;
    // Floppy and serial ranges meet at 3f0-3ff.
    wire logic hit = drv || io_addr inside {16'h0060, 16'h0064,
        [16'h02f8:16'h02ff], [16'h03f0:16'h03ff], [16'h0278:16'h027a],
        [16'h0378:16'h037a], [16'h03bc:16'h03be]};
    default clocking dc @(posedge clk); endclocking
    default disable iff (!arst_n);
    drive_wake_a: assert property (
        stby && io_cycle && drv |=> smi && pm_state == 3'h0)
        else $error("drive access kept standby");
    port_smi_a: assert property (
        stby && io_cycle && hit |=> smi)
        else $error("no smi on access");
    stop_idle_a: assert property (
        stop_clk |-> (stby && !smi) || susp)
        else $error("stop clock outside idle");
    standby_slow_a: assert property (
        stby |-> cpu_slow) else $error("standby at full speed");
    save_window_a: assert property (
        save_mem_open |-> smi) else $error("save memory open");
    tick_pulse_a: assert property (
        $rose(refresh_tick) |-> mem_refresh_slow ##1 !refresh_tick [*8])
        else $error("bad refresh tick");
    susp_clkgen_a: assert property (
        susp |-> clkgen_off && mem_refresh_slow)
        else $error("suspend clocks on");
    susp_video_a: assert property (
        susp |-> panel_off && dac_low) else $error("suspend with panel on");
endmodule

// >>> test/apm_periph_model.sv
/* Far side of the monitor: host I/O cycles and the interrupt and key pins.
   Assumes the bench raises requests just after rising clk edges. */
module apm_periph_model (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Requests from the bench
    input wire logic io_req,
    input wire logic [15:0] io_req_addr,
    input wire logic key_req,
    input wire logic [1:0] irq_req,
    // Pins toward the monitor
    output logic io_cycle,
    output logic [15:0] io_addr,
    output logic irq_kbd,
    output logic irq_mouse,
    output logic susp_key
);
    assign {irq_mouse, irq_kbd} = irq_req;
    assign susp_key = key_req;
    // Far-side wake delays are not modelled.
    // An idle bus inverts its address on every cycle.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            io_cycle <= 1'b0;
            io_addr <= 16'h0000;
        end else begin
            io_cycle <= io_req;
            io_addr <= io_req ? io_req_addr : ~io_addr;
        end
    end
endmodule

// >>> test/test_activity_power_monitor.sv
/* Self-checking bench for the activity power monitor.
   Assumes apm_pkg, apm_monitor, its checker and the far-side model. */
module test_activity_power_monitor;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TICK = apm_pkg::CLK_HZ / 32000;
    logic clk, arst_n, reg_wr, reg_rd, io_req, key_req, io_cycle, smi;
    logic irq_kbd, irq_mouse, susp_key, stop_clk, cpu_slow, clkgen_off;
    logic mem_refresh_slow, refresh_tick, panel_off, dac_low;
    logic gfx_suspend, gfx_standby, save_mem_open;
    logic [1:0] irq_req;
    logic [2:0] pm_state;
    logic [7:0] reg_addr;
    logic [15:0] io_req_addr, io_addr;
    logic [31:0] reg_wdata, reg_rdata, v, w, seed;
    int n_errors = 0;
    int tests_run = 0;
    int k;
    logic [15:0] lo [10] = '{16'h0060, 16'h0064, 16'h01f0, 16'h0170,
        16'h0376, 16'h03f8, 16'h02f8, 16'h0378, 16'h0278, 16'h03bc};
    int span [10] = '{0, 0, 7, 7, 0, 7, 7, 2, 2, 2};
    apm_monitor #(.QUIET_CYC(100)) apm_monitor_inst (.clk, .arst_n,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .io_cycle,
        .io_addr, .irq_kbd, .irq_mouse, .susp_key, .smi, .stop_clk,
        .cpu_slow, .clkgen_off, .mem_refresh_slow, .refresh_tick,
        .panel_off, .dac_low, .gfx_suspend, .gfx_standby, .save_mem_open,
        .pm_state);
    apm_periph_model apm_periph_model_inst (.clk, .arst_n, .io_req,
        .io_req_addr, .key_req, .irq_req, .io_cycle, .io_addr, .irq_kbd,
        .irq_mouse, .susp_key);
    // ********************
    // Helpers
    // ********************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
        @(posedge clk);
    endtask
    task automatic poke(input logic [15:0] a);
        io_req_addr <= a;
        io_req <= 1'b1;
        @(posedge clk);
        io_req <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_st(input logic [2:0] s);
        for (k = 0; k < 40000 && pm_state !== s; k++) @(posedge clk);
        cmp(32'(pm_state), 32'(s));
    endtask
    task automatic load(input logic [31:0] stby, input logic [31:0] sus);
        wr(apm_pkg::R_SUSP_TO, sus);
        wr(apm_pkg::R_STBY_TO, stby);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ********************
    // Clock, watchdog and scenarios
    // ********************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #450us;
        n_errors++;
        end_of_test();
    end
    initial begin
        seed = 32'd48;
        arst_n = 1'b0;
        {reg_wr, reg_rd, io_req, key_req, irq_req} = '0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        io_req_addr = 16'h0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(apm_pkg::R_STBY_TO);
        cmp(v, apm_pkg::STBY_TO_RST);
        rd(apm_pkg::R_SUSP_TO);
        cmp(v, apm_pkg::SUSP_TO_RST);
        rd(8'hfc);
        cmp(v, 32'h0);
        load(32'h4, 32'hffff);
        // Ports, both irq lines, then an unwatched port.
        for (int j = 0; j < 13; j++) begin
            wait_st(3'h1);
            wr(apm_pkg::R_CTRL, 32'h10);
            @(negedge clk);
            cmp(32'({cpu_slow, stop_clk}), 32'h3);
            if (j == 10 || j == 11)
                irq_req <= 2'(j - 9);
            else if (j < 10)
                poke(lo[j] + 16'(rnd() % 32'(span[j] + 1)));
            else
                poke(16'h0080 | 16'(rnd() & 32'hf));
            for (k = 0; k < 8 && smi !== 1'b1; k++) @(posedge clk);
            @(negedge clk);
            cmp(32'({smi, pm_state}), j < 12 ? 32'h8 : 32'h1);
            @(posedge clk);
            irq_req <= 2'b00;
            wr(apm_pkg::R_CTRL, 32'h10);
        end
        key_req <= 1'b1;
        repeat (4) @(posedge clk);
        key_req <= 1'b0;
        for (k = 0; k < 8 && smi !== 1'b1; k++) @(posedge clk);
        cmp(32'(smi), 32'h1);
        wr(apm_pkg::R_CTRL, 32'h4);
        wait_st(3'h2);
        repeat (2) begin
            poke(16'h01f3);
            repeat (60) @(posedge clk);
        end
        cmp(32'(pm_state), 32'h2);
        wait_st(3'h3);
        cmp(32'(save_mem_open), 32'h1);
        w = rnd();
        wr(apm_pkg::R_SAVE_ADDR, 32'h3);
        wr(apm_pkg::R_SAVE_DATA, w);
        rd(apm_pkg::R_SAVE_DATA);
        cmp(v, w);
        wr(apm_pkg::R_CTRL, 32'h8);
        wait_st(3'h4);
        cmp(32'({clkgen_off, panel_off, dac_low, mem_refresh_slow}), 32'hf);
        for (k = 0; k < 8000 && refresh_tick !== 1'b1; k++) @(posedge clk);
        @(posedge clk);
        for (k = 1; k < 8000 && refresh_tick !== 1'b1; k++) @(posedge clk);
        cmp(32'(k), 32'(TICK));
        wr(apm_pkg::R_CTRL, 32'h10);
        rd(apm_pkg::R_SAVE_DATA);
        cmp(v | 32'(save_mem_open), 32'h0);
        wr(apm_pkg::R_CTRL, 32'h80);
        wait_st(3'h0);
        load(32'h40, 32'h2);
        irq_req <= 2'b11;
        foreach (lo[j]) poke(lo[j]);
        poke(16'h03f0);
        irq_req <= 2'b00;
        for (k = 0; k < 40000 && pm_state === 3'h0; k++) @(posedge clk);
        cmp(32'(pm_state === 3'h1 || pm_state === 3'h0), 32'h0);
        wr(apm_pkg::R_CTRL, 32'h40);
        repeat (2) @(negedge clk);
        cmp(32'({gfx_suspend, gfx_standby}), 32'h1);
        end_of_test();
    end
endmodule
bind apm_monitor apm_monitor_chk apm_monitor_chk_inst (.clk, .arst_n,
    .io_cycle, .io_addr, .smi, .stop_clk, .cpu_slow, .clkgen_off,
    .mem_refresh_slow, .refresh_tick, .panel_off, .dac_low,
    .save_mem_open, .pm_state);
